/* rtl/pmic_regs_pkg.sv */
/*
  Constants for the power-management event register bank: register indices,
  field masks, reset values and Wishbone decode widths.
  Assumes a classic Wishbone slave with 32-bit data, one register per word.
*/
// Function
// RL1: Latch bits stay set until software writes one there; zero leaves them.
// RL2: Undervoltage-category bits return to defaults when input supply crosses threshold.
// RL3: Mirror-category bits reload from programmed memory contents.
// RL4: Off-mode-category bits return to defaults whenever device enters OFF mode.
// RL5: Backup-category bits reset only when backup supply loses valid input; the scratch also clears on reset.
// RL6: Test-write registers accept writes only in test board mode, else read-only.
// RL7: Set mask bit blocks its latched event from interrupt; live bits unlatched.
package pmic_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  localparam int ADDR_WIDTH = 8;
  localparam int REG_WIDTH  = 8;
  localparam int NUM_GROUPS = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Printed offsets are register indices; byte address is four times each
  localparam logic [5:0] IDX_DEVICE_IDENTITY  = 6'h00;
  localparam logic [5:0] IDX_SILICON_REVISION = 6'h01;
  localparam logic [5:0] IDX_PROGRAM_ID_HIGH  = 6'h02;
  localparam logic [5:0] IDX_PROGRAM_ID_LOW   = 6'h03;
  localparam logic [5:0] IDX_SYSTEM_LATCH     = 6'h04;
  localparam logic [5:0] IDX_SYSTEM_MASK      = 6'h05;
  localparam logic [5:0] IDX_SYSTEM_LIVE      = 6'h06;
  localparam logic [5:0] IDX_THERMAL_LATCH    = 6'h07;
  localparam logic [5:0] IDX_THERMAL_MASK     = 6'h08;
  localparam logic [5:0] IDX_THERMAL_LIVE     = 6'h09;
  localparam logic [5:0] IDX_BUCK_MODE_LATCH  = 6'h0a;
  localparam logic [5:0] IDX_BUCK_MODE_MASK   = 6'h0b;
  localparam logic [5:0] IDX_BUCK_ILIM_LATCH  = 6'h12;
  localparam logic [5:0] IDX_BUCK_ILIM_MASK   = 6'h13;
  localparam logic [5:0] IDX_BUCK_ILIM_LIVE   = 6'h14;
  localparam logic [5:0] IDX_LDO_ILIM_LATCH   = 6'h15;
  localparam logic [5:0] IDX_LINEAR_CURRENT_LIMIT_MASK    = 6'h16;
  localparam logic [5:0] IDX_LDO_ILIM_LIVE    = 6'h17;
  // Test-write scratch register, placed past the event bank
  localparam logic [5:0] IDX_TEST_SCRATCH     = 6'h30;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented bits per group: system, thermal, buck mode, buck ilim, ldo ilim
  localparam logic [7:0] SYSTEM_BITS    = 8'hff;
  localparam logic [7:0] SYSTEM_LIVE    = 8'h07;
  localparam logic [7:0] THERMAL_BITS   = 8'hff;
  localparam logic [7:0] BUCK_BITS      = 8'h4f;
  localparam logic [7:0] LDO_BITS       = 8'h03;
  localparam logic [7:0] MASK_RESET     = 8'hff;
  localparam logic [7:0] LATCH_RESET    = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [3:0] PROG_HIGH_LSB  = 4'h4;
  localparam logic [2:0] REV_RESET      = 3'h0;

  // Group order inside the latch/mask vectors
  localparam int GRP_SYSTEM    = 0;
  localparam int GRP_THERMAL   = 1;
  localparam int GRP_BUCK_MODE = 2;
  localparam int GRP_BUCK_ILIM = 3;
  localparam int GRP_LDO_ILIM  = 4;
  localparam int GRP_SPARE     = 5;

endpackage

/* rtl/event_latch_group.sv */
/*
  One group of eight write-one-to-clear event latches with a mask.
  Assumes events are synchronous single-cycle or level inputs.
*/
`timescale 1ns/1ns
module event_latch_group #(
  parameter logic [7:0] BITS = 8'hff
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       clear,
  // Events and software access
  input  wire logic [7:0] events,
  input  wire logic       clearStrobe,
  input  wire logic [7:0] clearData,
  input  wire logic       maskStrobe,
  input  wire logic [7:0] maskData,
  input  wire logic       maskClear,
  // State
  output logic      [7:0] latch,
  output logic      [7:0] mask,
  output logic            pending
);

  logic [7:0] nxt_latch;
  logic [7:0] nxt_mask;
  logic [7:0] latchFf;
  logic [7:0] maskFf;

  // Set wins over a same-cycle clear so no event is lost
  assign nxt_latch = ((latchFf & ~(clearStrobe ? clearData : 8'h00)) | events) & BITS; // [RL1]
  assign nxt_mask  = maskStrobe ? (maskData & BITS) : maskFf;

  always_ff @(posedge clk) begin
    if (clear) begin
      latchFf <= pmic_regs_pkg::LATCH_RESET; // [RL2]
    end else begin
      latchFf <= nxt_latch;
    end
  end

  always_ff @(posedge clk) begin
    if (maskClear) begin
      maskFf <= pmic_regs_pkg::MASK_RESET & BITS; // [RL4]
    end else begin
      maskFf <= nxt_mask;
    end
  end

  assign latch   = latchFf;
  assign mask    = maskFf;
  assign pending = |(latchFf & ~maskFf); // [RL7]

endmodule

/* rtl/mirror_loader.sv */
/*
  Holds the program identity fields mirrored from one-time memory.
  Assumes otpLoad pulses high while the mirror contents are stable.
*/
`timescale 1ns/1ns
module mirror_loader (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Mirror source
  input  wire logic        otpLoad,
  input  wire logic [11:0] otpProgramId,
  // Mirror contents
  output logic      [11:0] programId
);

  logic [11:0] programIdFf;

  always_ff @(posedge clk) begin
    if (reset) begin
      programIdFf <= 12'h000;
    end else if (otpLoad) begin
      programIdFf <= otpProgramId; // [RL3]
    end
  end

  assign programId = programIdFf;

endmodule

/* rtl/pmic_interrupt_status_regs.sv */
/*
  Event register bank of a multi-rail power manager: identity, latch, mask
  and live registers reached over classic Wishbone, plus reset categories.
  Assumes all condition inputs are synchronous to clk.
*/
`timescale 1ns/1ns
module pmic_interrupt_status_regs #(
  parameter logic [7:0] DEVICE_IDENTITY  = 8'h5a, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h11  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Reset categories and modes
  input  wire logic        undervoltage_detect_level,
  input  wire logic        offModeEntry,
  input  wire logic        backup_supply_valid,
  input  wire logic        test_board_mode,
  // Mirror source
  input  wire logic        otpLoad,
  input  wire logic [11:0] otpProgramId,
  // Event inputs
  input  wire logic [7:0]  systemEvents,
  input  wire logic [7:0]  thermalEvents,
  input  wire logic [7:0]  buckModeEvents,
  input  wire logic [7:0]  buckIlimEvents,
  input  wire logic [7:0]  ldoIlimEvents,
  // Live condition inputs
  input  wire logic [7:0]  systemLive,
  input  wire logic [7:0]  thermalLive,
  input  wire logic [7:0]  buckIlimLive,
  input  wire logic [7:0]  ldoIlimLive,
  // Status outputs
  output logic             interruptOut,
  output logic [7:0]       testScratch
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset categories
  logic uvPrevFf;
  logic uvCross;
  logic backupLoss;
  logic latchClear;
  logic maskClear;

  always_ff @(posedge clk) begin
    // Track the level through reset so release shows no false crossing
    if (reset) begin
      uvPrevFf <= undervoltage_detect_level;
    end else begin
      uvPrevFf <= undervoltage_detect_level;
    end
  end

  // Either crossing direction counts, so both edges clear
  assign uvCross    = undervoltage_detect_level ^ uvPrevFf; // [RL2]
  assign backupLoss = ~backup_supply_valid; // [RL5]
  assign latchClear = reset | uvCross; // [RL2]
  assign maskClear  = reset | offModeEntry; // [RL4]

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic       access;
  logic       writeStrobe;
  logic [5:0] regIndex;
  logic       wordAligned;
  logic       mapped;
  logic [7:0] writeByte;

  assign access      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign regIndex    = wb_adr_i[7:2];
  assign wordAligned = (wb_adr_i[1:0] == 2'h0);
  assign writeByte   = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign writeStrobe = access & wb_we_i & mapped & wb_sel_i[0];

  assign mapped = wordAligned & (
      regIndex <= pmic_regs_pkg::IDX_BUCK_MODE_MASK ||
      (regIndex >= pmic_regs_pkg::IDX_BUCK_ILIM_LATCH && regIndex <= pmic_regs_pkg::IDX_LDO_ILIM_LIVE) ||
      regIndex == pmic_regs_pkg::IDX_TEST_SCRATCH);

  ////////////////////////////////////////////////////////////////////////////
  // Event groups
  localparam int NG = pmic_regs_pkg::NUM_GROUPS;
  localparam logic [5:0] LATCH_IDX [NG] = '{
    pmic_regs_pkg::IDX_SYSTEM_LATCH, pmic_regs_pkg::IDX_THERMAL_LATCH,
    pmic_regs_pkg::IDX_BUCK_MODE_LATCH, pmic_regs_pkg::IDX_BUCK_ILIM_LATCH,
    pmic_regs_pkg::IDX_LDO_ILIM_LATCH, 6'h3f};
  localparam logic [5:0] MASK_IDX [NG] = '{
    pmic_regs_pkg::IDX_SYSTEM_MASK, pmic_regs_pkg::IDX_THERMAL_MASK,
    pmic_regs_pkg::IDX_BUCK_MODE_MASK, pmic_regs_pkg::IDX_BUCK_ILIM_MASK,
    pmic_regs_pkg::IDX_LINEAR_CURRENT_LIMIT_MASK, 6'h3f};
  localparam logic [7:0] GROUP_BITS [NG] = '{
    pmic_regs_pkg::SYSTEM_BITS, pmic_regs_pkg::THERMAL_BITS,
    pmic_regs_pkg::BUCK_BITS, pmic_regs_pkg::BUCK_BITS,
    pmic_regs_pkg::LDO_BITS, 8'h00};

  wire logic [7:0]    groupEvents [NG];
  wire logic [7:0]    groupLatch  [NG];
  wire logic [7:0]    groupMask   [NG];
  wire logic [NG-1:0] groupPending;

  assign groupEvents[pmic_regs_pkg::GRP_SYSTEM]    = systemEvents;
  assign groupEvents[pmic_regs_pkg::GRP_THERMAL]   = thermalEvents;
  assign groupEvents[pmic_regs_pkg::GRP_BUCK_MODE] = buckModeEvents;
  assign groupEvents[pmic_regs_pkg::GRP_BUCK_ILIM] = buckIlimEvents;
  assign groupEvents[pmic_regs_pkg::GRP_LDO_ILIM]  = ldoIlimEvents;
  assign groupEvents[pmic_regs_pkg::GRP_SPARE]     = 8'h00;

  genvar g;
  generate
    for (g = 0; g < NG - 1; g++) begin : gen_group
      logic clearHit;
      logic maskHit;
      assign clearHit = writeStrobe & (regIndex == LATCH_IDX[g]); // [RL1]
      assign maskHit  = writeStrobe & (regIndex == MASK_IDX[g]);
      event_latch_group #(
        .BITS (GROUP_BITS[g])
      ) u_group (
        .clk         (clk),
        .clear       (latchClear),
        .events      (groupEvents[g]),
        .clearStrobe (clearHit),
        .clearData   (writeByte),
        .maskStrobe  (maskHit),
        .maskData    (writeByte),
        .maskClear   (maskClear),
        .latch       (groupLatch[g]),
        .mask        (groupMask[g]),
        .pending     (groupPending[g])
      );
    end
  endgenerate

  // Spare slot keeps the vector width stable; it never holds events
  assign groupLatch[pmic_regs_pkg::GRP_SPARE]   = 8'h00;
  assign groupMask[pmic_regs_pkg::GRP_SPARE]    = 8'h00;
  assign groupPending[pmic_regs_pkg::GRP_SPARE] = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Identity mirror
  logic [11:0] programId;

  mirror_loader u_mirror (
    .clk          (clk),
    .reset        (reset),
    .otpLoad      (otpLoad),
    .otpProgramId (otpProgramId),
    .programId    (programId)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Test-write scratch, held on backup supply
  logic [7:0] scratchFf;
  logic [7:0] nxt_scratch;
  logic       scratchWrite;

  assign scratchWrite = writeStrobe & test_board_mode & (regIndex == pmic_regs_pkg::IDX_TEST_SCRATCH); // [RL6]
  assign nxt_scratch  = scratchWrite ? writeByte : scratchFf;

  always_ff @(posedge clk) begin
    if (reset | backupLoss) begin
      scratchFf <= pmic_regs_pkg::SCRATCH_RESET; // [RL5]
    end else begin
      scratchFf <= nxt_scratch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    unique case (regIndex)
      pmic_regs_pkg::IDX_DEVICE_IDENTITY:  readByte = DEVICE_IDENTITY;
      pmic_regs_pkg::IDX_SILICON_REVISION: readByte = SILICON_REVISION;
      pmic_regs_pkg::IDX_PROGRAM_ID_HIGH:  readByte = {programId[11:8], 1'b0, pmic_regs_pkg::REV_RESET};
      pmic_regs_pkg::IDX_PROGRAM_ID_LOW:   readByte = programId[7:0];
      pmic_regs_pkg::IDX_SYSTEM_LATCH:     readByte = groupLatch[pmic_regs_pkg::GRP_SYSTEM];
      pmic_regs_pkg::IDX_SYSTEM_MASK:      readByte = groupMask[pmic_regs_pkg::GRP_SYSTEM];
      pmic_regs_pkg::IDX_SYSTEM_LIVE:      readByte = systemLive & pmic_regs_pkg::SYSTEM_LIVE; // [RL7]
      pmic_regs_pkg::IDX_THERMAL_LATCH:    readByte = groupLatch[pmic_regs_pkg::GRP_THERMAL];
      pmic_regs_pkg::IDX_THERMAL_MASK:     readByte = groupMask[pmic_regs_pkg::GRP_THERMAL];
      pmic_regs_pkg::IDX_THERMAL_LIVE:     readByte = thermalLive; // [RL7]
      pmic_regs_pkg::IDX_BUCK_MODE_LATCH:  readByte = groupLatch[pmic_regs_pkg::GRP_BUCK_MODE];
      pmic_regs_pkg::IDX_BUCK_MODE_MASK:   readByte = groupMask[pmic_regs_pkg::GRP_BUCK_MODE];
      pmic_regs_pkg::IDX_BUCK_ILIM_LATCH:  readByte = groupLatch[pmic_regs_pkg::GRP_BUCK_ILIM];
      pmic_regs_pkg::IDX_BUCK_ILIM_MASK:   readByte = groupMask[pmic_regs_pkg::GRP_BUCK_ILIM];
      pmic_regs_pkg::IDX_BUCK_ILIM_LIVE:   readByte = buckIlimLive & pmic_regs_pkg::BUCK_BITS;
      pmic_regs_pkg::IDX_LDO_ILIM_LATCH:   readByte = groupLatch[pmic_regs_pkg::GRP_LDO_ILIM];
      pmic_regs_pkg::IDX_LINEAR_CURRENT_LIMIT_MASK:    readByte = groupMask[pmic_regs_pkg::GRP_LDO_ILIM];
      pmic_regs_pkg::IDX_LDO_ILIM_LIVE:    readByte = ldoIlimLive & pmic_regs_pkg::LDO_BITS;
      pmic_regs_pkg::IDX_TEST_SCRATCH:     readByte = scratchFf;
      default:                             readByte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, one cycle after the request is seen
  logic [31:0] nxt_dat;
  logic        nxt_ack;
  logic        nxt_err;

  assign nxt_ack = access & mapped;
  assign nxt_err = access & ~mapped;
  assign nxt_dat = (access & mapped & ~wb_we_i) ? {24'h000000, readByte} : 32'h00000000;

  logic [31:0] datFf;
  logic        ackFf;
  logic        errFf;
  logic        irqFf;

  always_ff @(posedge clk) begin
    if (reset) begin
      datFf <= 32'h00000000;
      ackFf <= 1'b0;
      errFf <= 1'b0;
      irqFf <= 1'b0;
    end else begin
      datFf <= nxt_dat;
      ackFf <= nxt_ack;
      errFf <= nxt_err;
      irqFf <= |groupPending; // [RL7]
    end
  end

  assign wb_dat_o     = datFf;
  assign wb_ack_o     = ackFf;
  assign wb_err_o     = errFf;
  assign interruptOut = irqFf;
  assign testScratch  = scratchFf;

endmodule

/* dv/pmic_regs_props.sv */
/*
  Port-level assertions for the event register bank.
  Bound to the top module from the bench; sees its ports only.
*/
`timescale 1ns/1ns
module pmic_regs_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Modes and status
  input wire logic        offModeEntry,
  input wire logic        backup_supply_valid,
  input wire logic        test_board_mode,
  input wire logic        interruptOut,
  input wire logic [7:0]  testScratch
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic req;
  logic scratchWr;
  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // Backup loss also moves the scratch, so it is excluded here
  assign scratchWr = req & wb_we_i & (wb_adr_i == 8'hc0) & backup_supply_valid;

  ////////////////////////////////////////////////////////////////////////////
  property p_answer; req |=> wb_ack_o ^ wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");
  property p_pulse; wb_ack_o | wb_err_o |=> !wb_ack_o && !wb_err_o; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
  property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_misaligned; req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o; endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");
  property p_backup; !backup_supply_valid |=> testScratch == 8'h00; endproperty
  a_backup: assert property (p_backup) else $error("scratch kept on backup loss");
  property p_tw_lock; scratchWr && !test_board_mode |=> $stable(testScratch); endproperty
  a_tw_lock: assert property (p_tw_lock) else $error("scratch written outside test mode");
  property p_tw_write;
    scratchWr && test_board_mode && wb_sel_i[0] |=> testScratch == $past(wb_dat_i[7:0]);
  endproperty
  a_tw_write: assert property (p_tw_write) else $error("scratch write lost in test mode");
  property p_off_irq; offModeEntry |-> ##2 !interruptOut; endproperty
  a_off_irq: assert property (p_off_irq) else $error("interrupt after masks restored");
endmodule

/* dv/pmic_interrupt_status_regs_tb.sv */
/*
  Self-checking bench for the event register bank.
  Drives every port itself; Wishbone answers come a cycle after the take.
*/
`timescale 1ns/1ns
module pmic_interrupt_status_regs_tb;
  logic        clk = 1'b0;
  logic        reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, interruptOut, lastErr;
  logic        undervoltage_detect_level, offModeEntry, backup_supply_valid, test_board_mode, otpLoad;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, testScratch, systemEvents, thermalEvents, buckModeEvents, buckIlimEvents;
  logic [7:0]  ldoIlimEvents, systemLive, thermalLive, buckIlimLive, ldoIlimLive;
  logic [11:0] otpProgramId;
  logic [31:0] wb_dat_i, wb_dat_o, rdData;
  int          err_total = 0;
  int          checks = 0;
  logic [7:0]  latchAdr [5] = '{8'h10, 8'h1c, 8'h28, 8'h48, 8'h54};
  logic [7:0]  implBits [5] = '{8'hff, 8'hff, 8'h4f, 8'h4f, 8'h03};

  pmic_interrupt_status_regs i_pmic_interrupt_status_regs (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .undervoltage_detect_level(undervoltage_detect_level),
    .offModeEntry(offModeEntry), .backup_supply_valid(backup_supply_valid),
    .test_board_mode(test_board_mode), .otpLoad(otpLoad), .otpProgramId(otpProgramId),
    .systemEvents(systemEvents), .thermalEvents(thermalEvents), .buckModeEvents(buckModeEvents),
    .buckIlimEvents(buckIlimEvents), .ldoIlimEvents(ldoIlimEvents), .systemLive(systemLive),
    .thermalLive(thermalLive), .buckIlimLive(buckIlimLive), .ldoIlimLive(ldoIlimLive),
    .interruptOut(interruptOut), .testScratch(testScratch));

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until answered
  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rdData = wb_dat_o;
    lastErr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    cmp(rdData, {24'h000000, exp});
  endtask

  task ev(input logic [7:0] v);
    {systemEvents, thermalEvents, buckModeEvents, buckIlimEvents, ldoIlimEvents} <= {5{v}};
    @(posedge clk);
    {systemEvents, thermalEvents, buckModeEvents, buckIlimEvents, ldoIlimEvents} <= 40'h0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset_vals;
    rd(8'h00, 8'h5a);
    bus(1'b1, 8'h00, 8'h00);
    rd(8'h00, 8'h5a);
    rd(8'h04, 8'h11);
    for (int i = 0; i < 5; i++) begin
      rd(latchAdr[i], 8'h00);
      rd(latchAdr[i] + 8'h04, implBits[i]);
    end
  endtask

  task t_latch;
    ev(8'hff);
    for (int i = 0; i < 5; i++) begin
      rd(latchAdr[i], implBits[i]);
      // Lane 0 disabled: acked but nothing may clear
      wb_sel_i <= 4'h0;
      bus(1'b1, latchAdr[i], 8'hff);
      wb_sel_i <= 4'h1;
      rd(latchAdr[i], implBits[i]);
      bus(1'b1, latchAdr[i], 8'h00);
      rd(latchAdr[i], implBits[i]);
      bus(1'b1, latchAdr[i], 8'h01);
      rd(latchAdr[i], implBits[i] & 8'hfe);
      bus(1'b1, latchAdr[i], 8'hff);
      rd(latchAdr[i], 8'h00);
    end
  endtask

  task t_irq_live;
    ev(8'h01);
    cmp({31'h0, interruptOut}, 32'h0);
    bus(1'b1, 8'h14, 8'hfe);
    cmp({31'h0, interruptOut}, 32'h1);
    bus(1'b1, 8'h10, 8'h01);
    cmp({31'h0, interruptOut}, 32'h0);
    for (int i = 0; i < 5; i++) bus(1'b1, latchAdr[i], 8'hff);
    {systemLive, thermalLive, buckIlimLive, ldoIlimLive} <= {8'hff, 8'ha5, 8'hff, 8'hff};
    rd(8'h18, 8'h07);
    rd(8'h24, 8'ha5);
    rd(8'h50, 8'h4f);
    rd(8'h5c, 8'h03);
    thermalLive <= 8'h5a;
    rd(8'h24, 8'h5a);
  endtask

  task t_uv;
    for (int k = 0; k < 2; k++) begin
      ev(8'h81);
      undervoltage_detect_level <= ~undervoltage_detect_level;
      @(posedge clk);
      rd(8'h10, 8'h00);
      rd(8'h54, 8'h00);
      cmp({31'h0, interruptOut}, 32'h0);
    end
  endtask

  task t_off_otp;
    bus(1'b1, 8'h14, 8'h00);
    bus(1'b1, 8'h58, 8'h00);
    offModeEntry <= 1'b1;
    otpProgramId <= 12'habc;
    otpLoad <= 1'b1;
    @(posedge clk);
    offModeEntry <= 1'b0;
    otpLoad <= 1'b0;
    @(posedge clk);
    rd(8'h14, 8'hff);
    rd(8'h58, 8'h03);
    rd(8'h08, 8'ha0);
    rd(8'h0c, 8'hbc);
  endtask

  task t_scratch_err;
    bus(1'b1, 8'hc0, 8'h3c);
    rd(8'hc0, 8'h00);
    test_board_mode <= 1'b1;
    bus(1'b1, 8'hc0, 8'h3c);
    test_board_mode <= 1'b0;
    cmp({24'h0, testScratch}, 32'h3c);
    rd(8'hc0, 8'h3c);
    backup_supply_valid <= 1'b0;
    repeat (2) @(posedge clk);
    backup_supply_valid <= 1'b1;
    rd(8'hc0, 8'h00);
    bus(1'b1, 8'h60, 8'hff);
    cmp({31'h0, lastErr}, 32'h1);
    bus(1'b0, 8'h11, 8'h00);
    cmp({31'h0, lastErr}, 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset <= 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= '0;
    wb_sel_i <= 4'h1;
    {undervoltage_detect_level, offModeEntry, test_board_mode, otpLoad} <= 4'h0;
    backup_supply_valid <= 1'b1;
    otpProgramId <= 12'h000;
    {systemEvents, thermalEvents, buckModeEvents, buckIlimEvents, ldoIlimEvents} <= 40'h0;
    {systemLive, thermalLive, buckIlimLive, ldoIlimLive} <= 32'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_vals;
    t_latch;
    t_irq_live;
    t_uv;
    t_off_otp;
    t_scratch_err;
    complete_run;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    complete_run;
  end
endmodule

bind pmic_interrupt_status_regs pmic_regs_props i_pmic_regs_props (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .offModeEntry(offModeEntry),
  .backup_supply_valid(backup_supply_valid), .test_board_mode(test_board_mode),
  .interruptOut(interruptOut), .testScratch(testScratch));
